// ===== hw/fcs_pkg.sv
// Behaviour
// R1: 16-bit words, even addresses, command high byte ignored
// R2: code FF selects array read until next command
// R3: code 70 makes next even read return status
// R4: host avoids read status in suspendable mode
// R5: code 50 clears both error flags
// R6: code 40 then word programs that address
// R7: ready low throughout auto program, high after
// R8: program error flag reports program result
// R9: no reprogramming, no programming of locked blocks
// R10: resident mode program enters status read mode
// R11: code 20 then D0 erases block
// R12: erase error flag reports; locked blocks protected
// R13: resident mode erase stays status until read
// R14: A7 then D0 erases unlocked blocks 0..12
// R15: 77 then D0 clears block lock bit
// R16: 71 then D0 copies lock bit to status
// R17: lock commands outside user area are errors
// R18: host never rewrites the rewrite program
// R19: host blocks DMA while busy in suspendable mode
// R20: host avoids rewrite commands while clock stopped
// R21: host clears rewrite enable before wait/stop
// R22: error flags set refuse program, erase, lock program
// R23: bad sequence sets both error flags
// R24: FF second cycle abandons command, array read
// R25: status bit 7 follows ready; others zero (code drives bit 5 from erase error, bit 4 from program error)
package fcs_pkg;
  // ****************************************
  // bus
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fcs_bus_req_t;
  // top address bit selects the control registers
  localparam int REG_SPACE_BIT = ADDR_W - 1;
  localparam logic [ADDR_W-1:0] CTRL0_OFF = 16'h8000;
  localparam logic [ADDR_W-1:0] CTRL1_OFF = 16'h8002;
  // ****************************************
  // register fields
  // ****************************************
  localparam int C0_READY = 0;
  localparam int C0_REWRITE_EN = 1;
  localparam int C0_LOCK_DIS = 2;
  localparam int C0_PROG_ERR = 6;
  localparam int C0_ERASE_ERR = 7;
  localparam int C1_SUSP_MODE = 1;
  localparam int C1_AREA_LO = 2;
  localparam int C1_LOCK_STAT = 6;
  localparam logic [1:0] AREA_USER = 2'h0;
  localparam int SR_SEQ = 7;
  localparam int SR_ERASE = 5;
  localparam int SR_PROG = 4;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 2000;
  localparam int ERASE_TIME_NS = 20000;
  localparam int LOCK_TIME_NS = 2000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_SECOND, SEQ_PROG, SEQ_ERASE, SEQ_ERASE_ALL, SEQ_LOCK
  } fcs_seq_t;
  typedef enum logic {MODE_ARRAY, MODE_STATUS} fcs_rmode_t;
endpackage : fcs_pkg

// ===== hw/fcs_sequencer.sv
`timescale 1ns/100ps
module fcs_sequencer #(
  parameter int NUM_BLOCKS = 14,
  parameter int BLOCK_WORDS = 8,
  parameter int PROG_CYC = fcs_pkg::PROG_CYC,
  parameter int ERASE_CYC = fcs_pkg::ERASE_CYC,
  parameter int LOCK_CYC = fcs_pkg::LOCK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register and array bus
  input wire fcs_pkg::fcs_bus_req_t busReq,
  output logic [fcs_pkg::DATA_W-1:0] rdData,
  // sequencer state
  output logic readyOut
);
  localparam int WORDS = NUM_BLOCKS * BLOCK_WORDS;
  localparam int WIDX_W = $clog2(WORDS);
  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int CNT_W = $clog2(ERASE_CYC + PROG_CYC + LOCK_CYC + 1);
  // erase all ends at block 12, one before the last block
  localparam logic [BLK_W-1:0] LAST_ALL_BLK = BLK_W'(NUM_BLOCKS - 2);

  typedef struct packed {
    fcs_pkg::fcs_seq_t seq;
    fcs_pkg::fcs_rmode_t rmode;
    logic [7:0] pendCmd;
    logic [WIDX_W-1:0] pendWord;
    logic ready;
    logic progErr;
    logic eraseErr;
    logic rewriteEn;
    logic lockDis;
    logic suspMode;
    logic [1:0] area;
    logic lockStat;
    logic [CNT_W-1:0] timer;
    logic [BLK_W-1:0] blk;
    logic [WIDX_W-1:0] opWord;
    logic [15:0] opData;
    logic [NUM_BLOCKS-1:0] lockBit;
    logic [WORDS-1:0] written;
    logic [WORDS-1:0][15:0] mem;
    logic [15:0] rdData;
  } fcs_state_t;

  fcs_state_t state_reg;
  fcs_state_t state_next;

  // ****************************************
  // address decode
  // ****************************************
  logic regSpace;
  logic evenAddr;
  logic inArray;
  logic [WIDX_W-1:0] wordIdx;
  logic [BLK_W-1:0] blkIdx;
  logic blkTop;
  logic [7:0] cmdCode;
  logic [7:0] statusByte;

  assign regSpace = busReq.addr[fcs_pkg::REG_SPACE_BIT];
  assign evenAddr = ~busReq.addr[0]; // R1
  assign wordIdx = busReq.addr[WIDX_W:1];
  assign inArray = !regSpace && (32'(wordIdx) < WORDS);
  assign blkIdx = BLK_W'(32'(wordIdx) / BLOCK_WORDS);
  assign blkTop = (32'(wordIdx) % BLOCK_WORDS) == (BLOCK_WORDS - 1);
  assign cmdCode = busReq.wdata[7:0]; // R1

  always_comb begin
    statusByte = 8'h00; // R25
    statusByte[fcs_pkg::SR_SEQ] = state_reg.ready; // R25
    statusByte[fcs_pkg::SR_ERASE] = state_reg.eraseErr;
    statusByte[fcs_pkg::SR_PROG] = state_reg.progErr;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic locked;
    logic errBlock;
    logic cmdOk;
    state_next = state_reg;
    locked = state_reg.lockBit[blkIdx] == 1'b0 && !state_reg.lockDis;
    errBlock = state_reg.progErr || state_reg.eraseErr; // R22
    cmdOk = busReq.wr && inArray && evenAddr && state_reg.rewriteEn;

    // ---- reads, data stands one cycle after the strobe
    state_next.rdData = 16'h0000;
    if (busReq.rd) begin
      if (regSpace) begin
        if (busReq.addr == fcs_pkg::CTRL0_OFF) begin
          state_next.rdData[fcs_pkg::C0_READY] = state_reg.ready;
          state_next.rdData[fcs_pkg::C0_REWRITE_EN] = state_reg.rewriteEn;
          state_next.rdData[fcs_pkg::C0_LOCK_DIS] = state_reg.lockDis;
          state_next.rdData[fcs_pkg::C0_PROG_ERR] = state_reg.progErr;
          state_next.rdData[fcs_pkg::C0_ERASE_ERR] = state_reg.eraseErr;
        end else if (busReq.addr == fcs_pkg::CTRL1_OFF) begin
          state_next.rdData[fcs_pkg::C1_SUSP_MODE] = state_reg.suspMode;
          state_next.rdData[fcs_pkg::C1_AREA_LO +: 2] = state_reg.area;
          state_next.rdData[fcs_pkg::C1_LOCK_STAT] = state_reg.lockStat; // R16
        end
      end else if (inArray && evenAddr) begin
        if (state_reg.rmode == fcs_pkg::MODE_STATUS) begin
          state_next.rdData = {8'h00, statusByte}; // R3
        end else begin
          state_next.rdData = state_reg.mem[wordIdx]; // R2
        end
      end
    end

    // ---- control register writes
    if (busReq.wr && regSpace) begin
      if (busReq.addr == fcs_pkg::CTRL0_OFF) begin
        state_next.rewriteEn = busReq.wdata[fcs_pkg::C0_REWRITE_EN];
        state_next.lockDis = busReq.wdata[fcs_pkg::C0_LOCK_DIS];
        // dropping rewrite enable also drops the suspendable mode
        if (!busReq.wdata[fcs_pkg::C0_REWRITE_EN]) begin
          state_next.suspMode = 1'b0;
        end
      end else if (busReq.addr == fcs_pkg::CTRL1_OFF) begin
        state_next.suspMode = busReq.wdata[fcs_pkg::C1_SUSP_MODE] && state_reg.rewriteEn;
        state_next.area = busReq.wdata[fcs_pkg::C1_AREA_LO +: 2];
      end
    end

    // ---- command sequencer
    case (state_reg.seq)
      fcs_pkg::SEQ_IDLE: begin
        if (cmdOk) begin
          state_next.pendCmd = cmdCode;
          state_next.pendWord = wordIdx;
          case (cmdCode)
            fcs_pkg::CMD_READ_ARRAY: state_next.rmode = fcs_pkg::MODE_ARRAY; // R2
            fcs_pkg::CMD_READ_STATUS: state_next.rmode = fcs_pkg::MODE_STATUS; // R3
            fcs_pkg::CMD_CLEAR_STATUS: begin
              state_next.progErr = 1'b0; // R5
              state_next.eraseErr = 1'b0; // R5
            end
            fcs_pkg::CMD_PROGRAM, fcs_pkg::CMD_BLOCK_ERASE, fcs_pkg::CMD_ERASE_ALL,
            fcs_pkg::CMD_LOCK_PROG, fcs_pkg::CMD_LOCK_READ: begin
              state_next.seq = fcs_pkg::SEQ_SECOND;
            end
            default: begin
              state_next.progErr = 1'b1; // R23
              state_next.eraseErr = 1'b1; // R23
            end
          endcase
        end
      end
      fcs_pkg::SEQ_SECOND: begin
        if (cmdOk) begin
          state_next.seq = fcs_pkg::SEQ_IDLE;
          if (state_reg.pendCmd == fcs_pkg::CMD_PROGRAM) begin
            if (wordIdx != state_reg.pendWord) begin
              state_next.progErr = 1'b1; // R23
              state_next.eraseErr = 1'b1;
            end else if (errBlock) begin
              // refused silently, error flags already tell why
              state_next.seq = fcs_pkg::SEQ_IDLE; // R22
            end else if (locked || state_reg.written[wordIdx]) begin
              state_next.progErr = 1'b1; // R9
            end else begin
              state_next.seq = fcs_pkg::SEQ_PROG; // R6
              state_next.ready = 1'b0; // R7
              state_next.timer = CNT_W'(PROG_CYC - 1);
              state_next.opWord = wordIdx;
              state_next.opData = busReq.wdata; // R6
              if (!state_reg.suspMode) begin
                state_next.rmode = fcs_pkg::MODE_STATUS; // R10
              end
            end
          end else if (cmdCode == fcs_pkg::CMD_READ_ARRAY) begin
            state_next.rmode = fcs_pkg::MODE_ARRAY; // R24
          end else if (cmdCode != fcs_pkg::CMD_CONFIRM) begin
            state_next.progErr = 1'b1; // R23
            state_next.eraseErr = 1'b1;
          end else if (state_reg.pendCmd == fcs_pkg::CMD_ERASE_ALL) begin
            if (!errBlock) begin // R22
              state_next.seq = fcs_pkg::SEQ_ERASE_ALL; // R14
              state_next.ready = 1'b0;
              state_next.blk = '0;
              state_next.timer = CNT_W'(ERASE_CYC - 1);
              if (!state_reg.suspMode) begin
                state_next.rmode = fcs_pkg::MODE_STATUS; // R13
              end
            end
          end else if (!blkTop) begin
            // confirm must land on the uppermost word of a block
            state_next.progErr = 1'b1; // R23
            state_next.eraseErr = 1'b1;
          end else if (state_reg.pendCmd == fcs_pkg::CMD_BLOCK_ERASE) begin
            if (errBlock) begin
              state_next.seq = fcs_pkg::SEQ_IDLE; // R22
            end else if (locked) begin
              state_next.eraseErr = 1'b1; // R12
            end else begin
              state_next.seq = fcs_pkg::SEQ_ERASE; // R11
              state_next.ready = 1'b0; // R11
              state_next.blk = blkIdx;
              state_next.timer = CNT_W'(ERASE_CYC - 1);
              if (!state_reg.suspMode) begin
                state_next.rmode = fcs_pkg::MODE_STATUS; // R13
              end
            end
          end else if (state_reg.area != fcs_pkg::AREA_USER) begin
            state_next.progErr = 1'b1; // R17
            state_next.eraseErr = 1'b1; // R17
          end else if (state_reg.pendCmd == fcs_pkg::CMD_LOCK_PROG) begin
            if (wordIdx != state_reg.pendWord) begin
              state_next.progErr = 1'b1; // R23
              state_next.eraseErr = 1'b1;
            end else if (!errBlock) begin // R22
              state_next.seq = fcs_pkg::SEQ_LOCK; // R15
              state_next.ready = 1'b0;
              state_next.blk = blkIdx;
              state_next.timer = CNT_W'(LOCK_CYC - 1);
              if (!state_reg.suspMode) begin
                state_next.rmode = fcs_pkg::MODE_STATUS;
              end
            end
          end else begin
            // lock read is immediate, ready never drops
            state_next.lockStat = state_reg.lockBit[blkIdx]; // R16
            state_next.rmode = fcs_pkg::MODE_ARRAY; // R13
          end
        end
      end
      fcs_pkg::SEQ_PROG: begin
        if (state_reg.timer == '0) begin
          state_next.mem[state_reg.opWord] = state_reg.opData; // R6
          state_next.written[state_reg.opWord] = 1'b1; // R9
          state_next.progErr = 1'b0; // R8
          state_next.ready = 1'b1; // R7
          state_next.seq = fcs_pkg::SEQ_IDLE;
        end else begin
          state_next.timer = state_reg.timer - CNT_W'(1);
        end
      end
      fcs_pkg::SEQ_ERASE, fcs_pkg::SEQ_ERASE_ALL: begin
        if (state_reg.seq == fcs_pkg::SEQ_ERASE_ALL && state_reg.lockBit[state_reg.blk] == 1'b0
            && !state_reg.lockDis) begin
          // locked blocks are skipped without spending erase time
          state_next.timer = CNT_W'(ERASE_CYC - 1); // R14
          state_next.blk = state_reg.blk + BLK_W'(1);
          if (state_reg.blk == LAST_ALL_BLK) begin
            state_next.ready = 1'b1;
            state_next.seq = fcs_pkg::SEQ_IDLE;
          end
        end else if (state_reg.timer == '0) begin
          for (int i = 0; i < WORDS; i++) begin
            if (i / BLOCK_WORDS == 32'(state_reg.blk)) begin
              state_next.mem[i] = fcs_pkg::ERASED_WORD;
              state_next.written[i] = 1'b0;
            end
          end
          state_next.lockBit[state_reg.blk] = 1'b1; // R12
          state_next.eraseErr = 1'b0; // R12
          state_next.timer = CNT_W'(ERASE_CYC - 1);
          state_next.blk = state_reg.blk + BLK_W'(1);
          if (state_reg.seq == fcs_pkg::SEQ_ERASE || state_reg.blk == LAST_ALL_BLK) begin // R14
            state_next.ready = 1'b1; // R11
            state_next.seq = fcs_pkg::SEQ_IDLE;
          end
        end else begin
          state_next.timer = state_reg.timer - CNT_W'(1);
        end
      end
      fcs_pkg::SEQ_LOCK: begin
        if (state_reg.timer == '0) begin
          state_next.lockBit[state_reg.blk] = 1'b0; // R15
          state_next.ready = 1'b1; // R15
          state_next.seq = fcs_pkg::SEQ_IDLE;
        end else begin
          state_next.timer = state_reg.timer - CNT_W'(1);
        end
      end
      default: state_next.seq = fcs_pkg::SEQ_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.seq <= fcs_pkg::SEQ_IDLE;
      state_reg.rmode <= fcs_pkg::MODE_ARRAY;
      state_reg.ready <= 1'b1;
      // array resets erased and unlocked; no retention across reset
      state_reg.lockBit <= '1;
      state_reg.mem <= {WORDS{fcs_pkg::ERASED_WORD}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData = state_reg.rdData;
  assign readyOut = state_reg.ready;
endmodule : fcs_sequencer

// ===== verification/fcs_sequencer_sva.sv
`timescale 1ns/100ps
module fcs_sequencer_sva #(
  parameter int NUM_BLOCKS = 14,
  parameter int BLOCK_WORDS = 8,
  parameter int ERASE_CYC = fcs_pkg::ERASE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus
  input wire fcs_pkg::fcs_bus_req_t busReq,
  input wire logic [fcs_pkg::DATA_W-1:0] rdData,
  input wire logic readyOut
);
  // ******
  // helpers
  // ******
  localparam int BUSY_MAX = (ERASE_CYC + 1) * NUM_BLOCKS;
  localparam int ARR_BYTES = NUM_BLOCKS * BLOCK_WORDS * 2;
  logic suspSeen_reg;
  logic [31:0] busyCnt_reg;
  logic evenArr;
  assign evenArr = !busReq.addr[fcs_pkg::REG_SPACE_BIT] && !busReq.addr[0] &&
    (busReq.addr < ARR_BYTES);
  // kept sticky: a refused write must never hide a real suspendable mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      suspSeen_reg <= 1'b0;
      busyCnt_reg <= 32'h0;
    end else begin
      suspSeen_reg <= suspSeen_reg | (busReq.wr && busReq.addr == fcs_pkg::CTRL1_OFF &&
        busReq.wdata[fcs_pkg::C1_SUSP_MODE]);
      busyCnt_reg <= readyOut ? 32'h0 : busyCnt_reg + 32'h1;
    end
  end
  // ******
  // properties
  // ******
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_arr_rd;
    busReq.rd && evenArr;
  endsequence
  sequence s_busy3;
    !readyOut [*3];
  endsequence
  property p_rd_idle;
    !busReq.rd |=> rdData == 16'h0000;
  endproperty
  property p_odd_rd;
    busReq.rd && !busReq.addr[fcs_pkg::REG_SPACE_BIT] && busReq.addr[0] |=> rdData == 16'h0000;
  endproperty
  property p_stat_busy;
    s_arr_rd ##0 (!readyOut && !suspSeen_reg) |=> rdData == 16'h0000;
  endproperty
  property p_ctrl0_rdy;
    busReq.rd && busReq.addr == fcs_pkg::CTRL0_OFF |=> rdData[0] == $past(readyOut);
  endproperty
  property p_fall_cause;
    $fell(readyOut) |-> $past(busReq.wr) && $past(evenArr);
  endproperty
  property p_rdy_hold;
    readyOut && !busReq.wr |=> readyOut;
  endproperty
  property p_min_busy;
    $fell(readyOut) |-> s_busy3;
  endproperty
  property p_busy_bound;
    busyCnt_reg <= BUSY_MAX;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_odd_rd: assert property (p_odd_rd) else $error("odd read not zero");
  a_stat_busy: assert property (p_stat_busy) else $error("busy status wrong");
  a_ctrl0_rdy: assert property (p_ctrl0_rdy) else $error("ready bit wrong");
  a_fall_cause: assert property (p_fall_cause) else $error("busy without write");
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped");
  a_min_busy: assert property (p_min_busy) else $error("busy too short");
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule : fcs_sequencer_sva

bind fcs_sequencer fcs_sequencer_sva #(
  .NUM_BLOCKS(NUM_BLOCKS),
  .BLOCK_WORDS(BLOCK_WORDS),
  .ERASE_CYC(ERASE_CYC)
) chk_u (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .busReq(busReq),
  .rdData(rdData),
  .readyOut(readyOut)
);

// ===== verification/fcs_cpu_model.sv
`timescale 1ns/100ps
module fcs_cpu_model (
  // clock
  input wire logic clk_sys,
  // bus
  output fcs_pkg::fcs_bus_req_t busReq,
  input wire logic [15:0] rdData
);
  initial begin
    busReq = '0;
  end
  // callers keep suspendable mode off, clock running
  // one 16-bit word at an even address per strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    busReq.wr <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
    busReq.addr <= ~a;
    busReq.wdata <= ~d;
  endtask : wr
  // released lines inverted so stale values never pass
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    busReq.rd <= 1'b1;
    busReq.addr <= a;
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    busReq.addr <= ~a;
    #1;
    d = rdData;
  endtask : rd
endmodule : fcs_cpu_model

// ===== verification/fcs_sequencer_tb.sv
`timescale 1ns/100ps
module fcs_sequencer_tb;
  // ******
  // set-up
  // ******
  localparam int P_CYC = 4;
  localparam int E_CYC = 5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  fcs_pkg::fcs_bus_req_t busReq;
  logic [15:0] rdData;
  logic readyOut;
  logic [15:0] d;
  int n;
  int err_count = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  fcs_cpu_model cpu_u (.clk_sys(clk_sys), .busReq(busReq), .rdData(rdData));
  fcs_sequencer #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC), .LOCK_CYC(P_CYC)) dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .busReq(busReq),
    .rdData(rdData),
    .readyOut(readyOut)
  );
  // ******
  // helpers
  // ******
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic st(input logic [15:0] e);
    cpu_u.wr(16'h0000, 16'h0070);
    cpu_u.rd(16'h0000, d);
    chk("status", e, d);
  endtask : st
  task automatic ar(input logic [15:0] a, input logic [15:0] e);
    cpu_u.wr(16'h0000, 16'h00FF);
    cpu_u.rd(a, d);
    chk("array word", e, d);
  endtask : ar
  task automatic lock_rd(input logic [15:0] a, input logic [15:0] e);
    cpu_u.wr(16'h0000, 16'h0071);
    cpu_u.wr(a, 16'h00D0);
    cpu_u.rd(16'h8002, d);
    chk("lock status", e, d & 16'h0040);
  endtask : lock_rd
  // counts busy cycles; the watchdog covers a hang
  task automatic wait_rdy();
    n = 0;
    #1;
    while (readyOut !== 1'b1 && n < 30000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_rdy
  // ******
  // scenarios
  // ******
  task automatic t_reset();
    cpu_u.rd(16'h8000, d);
    chk("control 0", 16'h0001, d & 16'h00C7);
    cpu_u.rd(16'h0020, d);
    chk("erased word", 16'hFFFF, d);
    cpu_u.rd(16'h0013, d);
    chk("odd read", 16'h0000, d);
    cpu_u.wr(16'h0000, 16'h0033);
    cpu_u.wr(16'h8000, 16'h0002);
    st(16'h0080);
  endtask : t_reset
  task automatic t_prog();
    cpu_u.wr(16'h0012, 16'hAB40);
    cpu_u.wr(16'h0012, 16'hA5C3);
    cpu_u.rd(16'h0020, d);
    chk("busy status", 16'h0000, d);
    wait_rdy();
    cpu_u.rd(16'h0020, d);
    chk("done status", 16'h0080, d);
    ar(16'h0012, 16'hA5C3);
    cpu_u.wr(16'h0012, 16'h0040);
    cpu_u.wr(16'h0012, 16'h1111);
    wait_rdy();
    st(16'h0090);
    cpu_u.wr(16'h0000, 16'h0050);
    st(16'h0080);
    ar(16'h0012, 16'hA5C3);
  endtask : t_prog
  task automatic t_error();
    cpu_u.wr(16'h0000, 16'h0033);
    st(16'h00B0);
    cpu_u.wr(16'h0014, 16'h0040);
    cpu_u.wr(16'h0014, 16'h2222);
    cpu_u.wr(16'h0000, 16'h0020);
    cpu_u.wr(16'h001E, 16'h00D0);
    st(16'h00B0);
    ar(16'h0014, 16'hFFFF);
    ar(16'h0012, 16'hA5C3);
    cpu_u.wr(16'h0000, 16'h0050);
  endtask : t_error
  task automatic t_erase();
    cpu_u.wr(16'h0000, 16'h0020);
    cpu_u.wr(16'h001E, 16'h00FF);
    cpu_u.rd(16'h0012, d);
    chk("abort read", 16'hA5C3, d);
    st(16'h0080);
    cpu_u.wr(16'h0000, 16'h0020);
    cpu_u.wr(16'h001E, 16'h00D0);
    wait_rdy();
    chk("erase cycles", 16'(E_CYC), n[15:0]);
    cpu_u.rd(16'h0000, d);
    chk("kept status", 16'h0080, d);
    ar(16'h0012, 16'hFFFF);
  endtask : t_erase
  task automatic t_lock();
    cpu_u.wr(16'h002E, 16'h0077);
    cpu_u.wr(16'h002E, 16'h00D0);
    wait_rdy();
    chk("lock cycles", 16'(P_CYC), n[15:0]);
    lock_rd(16'h002E, 16'h0000);
    lock_rd(16'h003E, 16'h0040);
    cpu_u.rd(16'h0012, d);
    chk("array after lock read", 16'hFFFF, d);
    cpu_u.wr(16'h0020, 16'h0040);
    cpu_u.wr(16'h0020, 16'h3333);
    wait_rdy();
    st(16'h0090);
    cpu_u.wr(16'h0000, 16'h0050);
    cpu_u.wr(16'h0000, 16'h0020);
    cpu_u.wr(16'h002E, 16'h00D0);
    wait_rdy();
    st(16'h00A0);
    cpu_u.wr(16'h0000, 16'h0050);
    cpu_u.wr(16'h8002, 16'h0004);
    cpu_u.wr(16'h0000, 16'h0071);
    cpu_u.wr(16'h002E, 16'h00D0);
    st(16'h00B0);
    cpu_u.wr(16'h8002, 16'h0000);
    cpu_u.wr(16'h0000, 16'h0050);
  endtask : t_lock
  task automatic t_erase_all();
    cpu_u.wr(16'h0000, 16'h0040);
    cpu_u.wr(16'h0000, 16'h5A5A);
    wait_rdy();
    chk("program cycles", 16'(P_CYC), n[15:0]);
    cpu_u.wr(16'h00D0, 16'h0040);
    cpu_u.wr(16'h00D0, 16'h6B6B);
    wait_rdy();
    cpu_u.wr(16'h0000, 16'h00A7);
    cpu_u.wr(16'h0000, 16'h00D0);
    wait_rdy();
    chk("erase all cycles", 16'(12 * E_CYC + 1), n[15:0]);
    ar(16'h0000, 16'hFFFF);
    ar(16'h00D0, 16'h6B6B);
    lock_rd(16'h002E, 16'h0000);
  endtask : t_erase_all
  // ******
  // run
  // ******
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_prog();
    t_error();
    t_erase();
    t_lock();
    t_erase_all();
    finish_test();
  end
endmodule : fcs_sequencer_tb
